// ==== verilog/rmru_map.svh ====
// Purpose: register offsets, reset values, opcodes and constants of the
//          reverse multiply-accumulate unit
// Assumes: byte addresses on the register bus, one 32-bit word per register
// Notes:   definitions only
`ifndef RMRU_MAP_SVH
`define RMRU_MAP_SVH

// register byte offsets
`define RMRU_OFS_CTRL       10'h000
`define RMRU_OFS_INSTR      10'h004
`define RMRU_OFS_OPERANDS   10'h008
`define RMRU_OFS_ACC_LO     10'h00c
`define RMRU_OFS_ACC_HI     10'h010
`define RMRU_OFS_FLAGS      10'h014
`define RMRU_OFS_INDEX      10'h018
`define RMRU_OFS_IRQ_STATUS 10'h01c
`define RMRU_OFS_IRQ_CLEAR  10'h020
`define RMRU_OFS_IRQ_ENABLE 10'h024
`define RMRU_OFS_DPRAM_BASE 10'h200

// control fields
`define RMRU_CTRL_SHIFT_BIT 0
`define RMRU_CTRL_SAT_BIT   1
`define RMRU_CTRL_RESET     2'h0

// interrupt status bit positions
`define RMRU_IRQ_DONE_BIT    0
`define RMRU_IRQ_OVF_BIT     1
`define RMRU_IRQ_SAT_BIT     2
`define RMRU_IRQ_ILLEGAL_BIT 3

// opcode bytes
`define RMRU_FORM_REG_REG   8'ha3
`define RMRU_FORM_REG_IND   8'h83
`define RMRU_FORM_IDX_IND   8'h93
`define RMRU_OP_SS_RND      8'hf1
`define RMRU_OP_SS          8'hf0
`define RMRU_OP_SU_RND      8'h71
`define RMRU_OP_SU          8'h70
`define RMRU_OP_UU_RND      8'h31
`define RMRU_OP_UU          8'h30
`define RMRU_OP_MSUB_SU     8'ha8
`define RMRU_INSTR_BYTES    4

// arithmetic constants
`define RMRU_ROUND_CONST    41'h00_0000_8000
`define RMRU_SAT_POS        40'h7f_ffff_ffff
`define RMRU_SAT_NEG        40'h80_0000_0000

`endif

// ==== verilog/rmru_pkg.sv ====
// Purpose: shared types of the reverse multiply-accumulate unit
// Assumes: constants live in rmru_map.svh
// Notes:   no constants here, only types
package rmru_pkg;

    // multiply flavour selected by the third opcode byte
    typedef enum logic [4:0] {
        RMRU_KIND_NONE = 5'b00001,
        RMRU_KIND_SS   = 5'b00010,
        RMRU_KIND_SU   = 5'b00100,
        RMRU_KIND_UU   = 5'b01000,
        RMRU_KIND_MSUB = 5'b10000
    } rmru_kind_t;

    // arithmetic flags, bit 6 down to bit 0
    typedef struct packed {
        logic overflow_flag;
        logic sticky_saturation_flag;
        logic extension_flag;
        logic sticky_overflow_flag;
        logic carry_flag;
        logic zero_flag;
        logic negative_flag;
    } rmru_flags_t;

    // decoded instruction
    typedef struct packed {
        rmru_kind_t kind;
        logic       round;
        logic       legal;
    } rmru_dec_t;

endpackage

// ==== verilog/rmru_unit.sv ====
// Purpose: reverse multiply-accumulate datapath with opcode decode,
//          flags, index-pointer move and an Avalon-MM register slave
// Assumes: one clock, asynchronous active-low reset, master holds requests
// Notes:   an instruction runs one cycle after its word is written
`timescale 1ns/1ns
`include "rmru_map.svh"

// Overview of operation
// - signed form: signed 16x16 product, sign-extended, shifted left if shift flag
// - reverse forms store extended product minus old accumulator
// - round forms add 8000h, then clear the low accumulator word
// - mixed forms: first operand signed, second unsigned, result sign-extended
// - unsigned form: unsigned product zero-extended before subtract and round
// - overflow flag set on 40-bit underflow, cleared otherwise
// - sticky overflow flag set on underflow, otherwise kept
// - sticky saturation flag set when saturation happens, otherwise kept
// - extension flag set when result reaches above bit 31
// - carry flag set on borrow, cleared otherwise
// - zero flag on zero result, negative flag follows bit 39
// - third byte f1 signed round, f0 signed plain; four-byte words
// - first byte a3, 83 or 93 selects the addressing form
// - third byte 71 is mixed reverse with round
// - third byte 70 is mixed reverse without round
// - bytes 93 and a8 give mixed subtract-and-move, index form only
// - subtract-and-move stores accumulator minus mixed product
// - move forms copy the index-pointer word to the destination word
module rmru_unit #(
    parameter int ADDR_W      = 10,
    parameter int DPRAM_WORDS = 64
) (
    input  wire logic                clock,
    input  wire logic                reset_n,
    input  wire logic [ADDR_W-1:0]   avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    output logic                     irq,
    output rmru_pkg::rmru_flags_t    flags
);

    localparam int IDX_W = $clog2(DPRAM_WORDS);

    // parameter sanity, the word window must end below the top of the address space
    if (ADDR_W < 10 || ADDR_W > 30 || DPRAM_WORDS < 2 || DPRAM_WORDS > 128 ||
        (DPRAM_WORDS & (DPRAM_WORDS - 1)) != 0 ||
        (`RMRU_OFS_DPRAM_BASE + DPRAM_WORDS * 4) >= (1 << ADDR_W))
    begin : g_bad_params
        $error("rmru_unit: unsupported ADDR_W or DPRAM_WORDS");
    end

    // merge write data into an old word under the byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = new_v[i*8 +: 8];
        return r;
    endfunction

    // sign-extend a 33-bit product to 40 bits
    function automatic logic [39:0] sext40(input logic [32:0] v);
        return {{7{v[32]}}, v};
    endfunction

    // registers
    logic [1:0]             ctrl_q;
    logic [31:0]            instr_q;
    logic [31:0]            operands_q;
    logic [39:0]            acc_q;
    logic [39:0]            acc_d;
    rmru_pkg::rmru_flags_t  flags_q;
    rmru_pkg::rmru_flags_t  flags_d;
    logic [31:0]            index_q;
    logic [3:0]             irq_status_q;
    logic [3:0]             irq_enable_q;
    logic                   irq_q;
    logic                   exec_q;
    logic                   wait_q;
    logic [31:0]            rdata_q;
    logic [31:0]            dpram_q [DPRAM_WORDS];

    // bus decode: a request completes on the edge where wait_q is low
    wire               bus_req   = avs_read | avs_write;
    wire               bus_done  = bus_req & ~wait_q;
    wire               wr_done   = avs_write & bus_done;
    wire [ADDR_W-1:0]  win_lo    = ADDR_W'(`RMRU_OFS_DPRAM_BASE);
    wire [ADDR_W-1:0]  win_hi    = ADDR_W'(`RMRU_OFS_DPRAM_BASE + DPRAM_WORDS * 4);
    wire               hit_dpram = (avs_address >= win_lo) && (avs_address < win_hi);
    wire [IDX_W-1:0]   bus_idx   = avs_address[IDX_W+1:2];
    wire               aligned   = (avs_address[1:0] == 2'h0);
    wire               wr_ctrl   = wr_done && avs_address == ADDR_W'(`RMRU_OFS_CTRL);
    wire               wr_instr  = wr_done && avs_address == ADDR_W'(`RMRU_OFS_INSTR);
    wire               wr_opnd   = wr_done && avs_address == ADDR_W'(`RMRU_OFS_OPERANDS);
    wire               wr_acclo  = wr_done && avs_address == ADDR_W'(`RMRU_OFS_ACC_LO);
    wire               wr_acchi  = wr_done && avs_address == ADDR_W'(`RMRU_OFS_ACC_HI);
    wire               wr_flags  = wr_done && avs_address == ADDR_W'(`RMRU_OFS_FLAGS);
    wire               wr_index  = wr_done && avs_address == ADDR_W'(`RMRU_OFS_INDEX);
    wire               wr_iclr   = wr_done && avs_address == ADDR_W'(`RMRU_OFS_IRQ_CLEAR);
    wire               wr_ien    = wr_done && avs_address == ADDR_W'(`RMRU_OFS_IRQ_ENABLE);
    wire               wr_dpram  = wr_done && hit_dpram && aligned;
    wire [31:0]        wdata_be  = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);

    // opcode decode from the latched instruction word
    wire [7:0] form_byte = instr_q[31:24];
    wire [7:0] op_byte   = instr_q[15:8];
    wire       form_ok   = (form_byte == `RMRU_FORM_REG_REG) ||
                           (form_byte == `RMRU_FORM_REG_IND) ||
                           (form_byte == `RMRU_FORM_IDX_IND);
    rmru_pkg::rmru_dec_t dec;

    // third byte picks the flavour; the move form needs the index form
    always_comb
    begin
        dec.kind  = rmru_pkg::RMRU_KIND_NONE;
        dec.round = 1'b0;
        case (op_byte)
            `RMRU_OP_SS_RND:  begin dec.kind = rmru_pkg::RMRU_KIND_SS; dec.round = 1'b1; end
            `RMRU_OP_SS:      dec.kind = rmru_pkg::RMRU_KIND_SS;
            `RMRU_OP_SU_RND:  begin dec.kind = rmru_pkg::RMRU_KIND_SU; dec.round = 1'b1; end
            `RMRU_OP_SU:      dec.kind = rmru_pkg::RMRU_KIND_SU;
            `RMRU_OP_UU_RND:  begin dec.kind = rmru_pkg::RMRU_KIND_UU; dec.round = 1'b1; end
            `RMRU_OP_UU:      dec.kind = rmru_pkg::RMRU_KIND_UU;
            `RMRU_OP_MSUB_SU:
            begin
                if (form_byte == `RMRU_FORM_IDX_IND)
                    dec.kind = rmru_pkg::RMRU_KIND_MSUB;
            end
            default:          dec.kind = rmru_pkg::RMRU_KIND_NONE;
        endcase
        dec.legal = form_ok && (dec.kind != rmru_pkg::RMRU_KIND_NONE);
    end

    // products of the three signedness flavours
    wire [15:0]        op_a   = operands_q[31:16];
    wire [15:0]        op_b   = operands_q[15:0];
    wire signed [32:0] p_ss   = $signed({op_a[15], op_a}) * $signed({op_b[15], op_b});
    wire signed [32:0] p_su   = $signed({op_a[15], op_a}) * $signed({1'b0, op_b});
    wire [32:0]        p_uu   = {1'b0, 32'(op_a) * 32'(op_b)};  // full width, not 16 bits
    wire               shift_en = ctrl_q[`RMRU_CTRL_SHIFT_BIT];
    wire               sat_en   = ctrl_q[`RMRU_CTRL_SAT_BIT];
    wire [39:0]        ss_ext   = sext40(p_ss);
    wire [39:0]        ss_sh    = shift_en ? {ss_ext[38:0], 1'b0} : ss_ext;
    wire [39:0]        su_ext   = sext40(p_su);
    wire [39:0]        uu_ext   = {7'h00, p_uu};
    logic [39:0]       ext_w;

    // extended product by flavour
    always_comb
    begin
        case (dec.kind)
            rmru_pkg::RMRU_KIND_SS:   ext_w = ss_sh;
            rmru_pkg::RMRU_KIND_SU:   ext_w = su_ext;
            rmru_pkg::RMRU_KIND_MSUB: ext_w = su_ext;
            rmru_pkg::RMRU_KIND_UU:   ext_w = uu_ext;
            default:                  ext_w = 40'h00_0000_0000;
        endcase
    end

    // reverse forms: product minus acc; move form: acc minus product
    wire        is_move  = (dec.kind == rmru_pkg::RMRU_KIND_MSUB);
    wire [39:0] minuend  = is_move ? acc_q : ext_w;
    wire [39:0] subtra   = is_move ? ext_w : acc_q;
    wire [40:0] rnd_add  = dec.round ? `RMRU_ROUND_CONST : 41'h0;
    wire [40:0] diff41   = {minuend[39], minuend} - {subtra[39], subtra} + rnd_add;
    wire [40:0] ubw      = {1'b0, minuend} - {1'b0, subtra};
    wire        ovf_w    = diff41[40] ^ diff41[39];
    wire        sat_w    = ovf_w & sat_en;
    wire [39:0] sat_val  = diff41[40] ? `RMRU_SAT_NEG : `RMRU_SAT_POS;
    wire [39:0] pre_res  = sat_w ? sat_val : diff41[39:0];
    wire [39:0] result_w = dec.round ? {pre_res[39:16], 16'h0000} : pre_res;

    // flag update for an executed instruction
    always_comb
    begin
        flags_d                        = flags_q;
        flags_d.overflow_flag          = ovf_w;
        flags_d.sticky_overflow_flag   = flags_q.sticky_overflow_flag | ovf_w;
        flags_d.sticky_saturation_flag = flags_q.sticky_saturation_flag | sat_w;
        flags_d.extension_flag         = ~((&result_w[39:31]) | ~(|result_w[39:31]));
        flags_d.carry_flag             = ubw[40];
        flags_d.zero_flag              = (result_w == 40'h00_0000_0000);
        flags_d.negative_flag          = result_w[39];
    end

    // narrow registers merged as full words, then cut to their width
    wire [31:0] ctrl_merge = be_merge({30'h0, ctrl_q}, avs_writedata, avs_byteenable);
    wire [31:0] hi_merge   = be_merge({24'h0, acc_q[39:32]}, avs_writedata, avs_byteenable);

    // accumulator next value: execution, then software writes
    always_comb
    begin
        acc_d = acc_q;
        if (exec_q && dec.legal)
            acc_d = result_w;
        else if (wr_acclo)
            acc_d[31:0] = be_merge(acc_q[31:0], avs_writedata, avs_byteenable);
        else if (wr_acchi)
            acc_d[39:32] = hi_merge[7:0];
    end

    // index-pointer copy addresses; source is the low half, destination is bits 16 up of the index word
    wire [IDX_W-1:0] src_idx  = index_q[IDX_W-1:0];
    wire [IDX_W-1:0] dst_idx  = index_q[16 +: IDX_W];
    wire             do_copy  = exec_q && dec.legal && is_move;
    wire [31:0]      src_word = dpram_q[src_idx];

    // events feeding the sticky interrupt status
    wire [3:0] irq_events = {exec_q & ~dec.legal,
                             exec_q & dec.legal & sat_w,
                             exec_q & dec.legal & ovf_w,
                             exec_q & dec.legal};
    wire [3:0] irq_clr    = wr_iclr ? wdata_be[3:0] : 4'h0;
    wire [3:0] status_d   = irq_events | (irq_status_q & ~irq_clr);   // set wins over clear

    // read mux, loaded while waitrequest is high
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_dpram && aligned)
            rd_mux = dpram_q[bus_idx];
        else
            case (avs_address)
                ADDR_W'(`RMRU_OFS_CTRL):       rd_mux = {30'h0, ctrl_q};
                ADDR_W'(`RMRU_OFS_INSTR):      rd_mux = instr_q;
                ADDR_W'(`RMRU_OFS_OPERANDS):   rd_mux = operands_q;
                ADDR_W'(`RMRU_OFS_ACC_LO):     rd_mux = acc_q[31:0];
                ADDR_W'(`RMRU_OFS_ACC_HI):     rd_mux = {24'h0, acc_q[39:32]};
                ADDR_W'(`RMRU_OFS_FLAGS):      rd_mux = {25'h0, flags_q};
                ADDR_W'(`RMRU_OFS_INDEX):      rd_mux = index_q;
                ADDR_W'(`RMRU_OFS_IRQ_STATUS): rd_mux = {28'h0, irq_status_q};
                ADDR_W'(`RMRU_OFS_IRQ_ENABLE): rd_mux = {28'h0, irq_enable_q};
                default:                       rd_mux = 32'h0000_0000;
            endcase
    end

    // bus handshake: one wait cycle per access
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q  <= ~(bus_req & wait_q);
            if (avs_read && wait_q)
                rdata_q <= rd_mux;
        end
    end

    // software-visible control and operand registers
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q     <= `RMRU_CTRL_RESET;
            instr_q    <= 32'h0000_0000;
            operands_q <= 32'h0000_0000;
            index_q    <= 32'h0000_0000;
            exec_q     <= 1'b0;
        end
        else
        begin
            exec_q <= wr_instr;
            if (wr_ctrl)
                ctrl_q <= ctrl_merge[1:0];
            if (wr_instr)
                instr_q <= be_merge(instr_q, avs_writedata, avs_byteenable);
            if (wr_opnd)
                operands_q <= be_merge(operands_q, avs_writedata, avs_byteenable);
            if (wr_index)
                index_q <= be_merge(index_q, avs_writedata, avs_byteenable);
        end
    end

    // accumulator and flags; execution beats a software flag write
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_q   <= 40'h00_0000_0000;
            flags_q <= '0;
        end
        else
        begin
            acc_q <= acc_d;
            if (exec_q && dec.legal)
                flags_q <= flags_d;
            else if (wr_flags)
                flags_q <= wdata_be[6:0];
        end
    end

    // interrupt status, enable and level output
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_status_q <= 4'h0;
            irq_enable_q <= 4'h0;
            irq_q        <= 1'b0;
        end
        else
        begin
            irq_status_q <= status_d;
            if (wr_ien)
                irq_enable_q <= wdata_be[3:0];
            irq_q <= |(status_d & (wr_ien ? wdata_be[3:0] : irq_enable_q));
        end
    end

    // dual-port word store; no reset, contents are data not control
    always_ff @(posedge clock)
    begin
        if (do_copy)
            dpram_q[dst_idx] <= src_word;
        else if (wr_dpram)
            dpram_q[bus_idx] <= be_merge(dpram_q[bus_idx], avs_writedata, avs_byteenable);
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign irq             = irq_q;
    assign flags           = flags_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    wire legal_exec = exec_q && dec.legal;

    sequence s_bus_wait;
        bus_req && wait_q;
    endsequence

    sequence s_bus_ack;
        !wait_q ##1 wait_q;
    endsequence

    chk_bus_handshake: assert property (s_bus_wait |=> s_bus_ack)
        else $error("waitrequest did not drop for exactly one cycle");

    chk_round_clears_low: assert property (legal_exec && dec.round |=> acc_q[15:0] == 16'h0000)
        else $error("low accumulator word not cleared by round form");

    chk_reverse_diff: assert property (legal_exec && !dec.round && !is_move && !sat_w
        |=> acc_q == $past(ext_w) - $past(acc_q))
        else $error("reverse form did not store product minus accumulator");

    chk_move_diff: assert property (legal_exec && is_move && !sat_w
        |=> acc_q == $past(acc_q) - $past(ext_w))
        else $error("move form did not store accumulator minus product");

    chk_sticky_keep: assert property (legal_exec && !ovf_w
        |=> flags_q.sticky_overflow_flag == $past(flags_q.sticky_overflow_flag))
        else $error("sticky overflow changed without underflow");

    chk_ovf_sticky_pair: assert property (legal_exec && ovf_w
        |=> flags_q.overflow_flag && flags_q.sticky_overflow_flag)
        else $error("underflow did not set both overflow flags");

    chk_zero_neg: assert property (legal_exec |=> flags_q.zero_flag == (acc_q == 40'h0)
        && flags_q.negative_flag == acc_q[39])
        else $error("zero or negative flag disagrees with result");

    chk_ext_flag: assert property (legal_exec |=> flags_q.extension_flag ==
        (acc_q[39:31] != 9'h000 && acc_q[39:31] != 9'h1ff))
        else $error("extension flag disagrees with result");

    chk_sat_clamp: assert property (legal_exec && sat_w && !dec.round
        |=> (acc_q == `RMRU_SAT_POS || acc_q == `RMRU_SAT_NEG)
        && flags_q.sticky_saturation_flag)
        else $error("saturation did not clamp or flag");

    chk_illegal_hold: assert property (exec_q && !dec.legal |=> $stable(acc_q) ##1 irq_status_q[3])
        else $error("illegal opcode changed accumulator or raised no event");

    chk_copy_word: assert property (do_copy |=> dpram_q[$past(dst_idx)] == $past(src_word))
        else $error("index-pointer word not copied");

    chk_irq_level: assert property (irq_q == |(irq_status_q & irq_enable_q))
        else $error("interrupt level disagrees with enabled status");

    chk_carry_borrow: assert property (legal_exec |=>
        flags_q.carry_flag == ($past(minuend) < $past(subtra)))
        else $error("carry flag disagrees with borrow");

endmodule // rmru_unit

// ==== bench/rmru_host_model.sv ====
// Purpose: CPU-side master that issues register accesses to the unit
// Assumes: req stays high until done is seen
// Notes:   done pulses at the edge where waitrequest was sampled low
`timescale 1ns/1ns
module rmru_host_model (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        req,
    input  wire logic        wr,
    input  wire logic [9:0]  addr,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic             done,
    output logic      [9:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    wire logic busy = avs_read | avs_write;
    // request held until waitrequest low; done blocks a relaunch of req
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {avs_read, avs_write, done, avs_address, avs_writedata, rdata} <= '0;
        end
        else if (busy && !avs_waitrequest)
        begin
            {avs_read, avs_write, done} <= 3'h1;
            rdata <= avs_readdata;
        end
        else if (req && !done && !busy)
        begin
            {avs_read, avs_write} <= {!wr, wr};
            avs_address <= addr;
            avs_writedata <= wdata;
        end
        else
            done <= 1'b0;
    end
endmodule // rmru_host_model

// ==== bench/reverse_mac_round_unit_tb_top.sv ====
// Purpose: random and corner checks of the reverse multiply-accumulate unit
// Assumes: one exec per INSTR write, flags port settled before next access ends
// Notes:   sticky flags tracked here, saturation chosen per run
`timescale 1ns/1ns
`include "rmru_map.svh"
module reverse_mac_round_unit_tb_top;
    logic clock, reset_n, req, wr, done, irq, avs_read, avs_write, avs_waitrequest, so, ss;
    logic [9:0] addr, avs_address;
    logic [31:0] wdata, rdata, avs_writedata, avs_readdata;
    rmru_pkg::rmru_flags_t flags;
    int errors, num_checks, cycles;
    logic [7:0] ops [7] = '{8'hf0, 8'hf1, 8'h70, 8'h71, 8'h30, 8'h31, 8'ha8};
    logic [7:0] forms [3] = '{8'ha3, 8'h83, 8'h93};
    rmru_unit uut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .flags(flags));
    rmru_host_model host (.clock(clock), .reset_n(reset_n), .req(req), .wr(wr),
        .addr(addr), .wdata(wdata), .rdata(rdata), .done(done),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    initial
    begin
        clock = 0;
        forever #4 clock = ~clock;
    end
    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard, well above the ~4000 cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            test_done();
        end
    end
    task automatic cmp(input string what, input logic [39:0] exp, input logic [39:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {req, wr, addr, wdata} <= {1'b1, w, a, d};
        do begin @(negedge clock); n++; end while (done !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        @(posedge clock);
        req <= 1'b0;
    endtask
    // returns {overflow, saturated, borrow, result}
    function automatic logic [42:0] model(input logic [7:0] op, input logic [31:0] o,
                                          input logic [39:0] a, input logic [1:0] c);
        logic signed [40:0] p, r;
        logic ovf;
        case (op)
            8'hf0, 8'hf1: p = $signed(o[31:16]) * $signed(o[15:0]);
            8'h30, 8'h31: p = {25'h0, o[31:16]} * {25'h0, o[15:0]};
            default:      p = $signed(o[31:16]) * $signed({1'b0, o[15:0]});
        endcase
        if (op[7:4] == 4'hf && c[0])
            p = p <<< 1;
        r = (op == 8'ha8) ? $signed({a[39], a}) - p : p - $signed({a[39], a});
        if (op[0])
            r = r + 41'sh8000;
        ovf = r[40] ^ r[39];
        if (ovf && c[1])
            r = r[40] ? 41'h1_80_0000_0000 : 41'h0_7f_ffff_ffff;
        if (op[0])
            r[15:0] = 16'h0;
        return {ovf, ovf & c[1], (op == 8'ha8) ? a < p[39:0] : p[39:0] < a, r[39:0]};
    endfunction
    task automatic run(input logic [7:0] f, input logic [7:0] op, input logic [31:0] o,
                       input logic [39:0] a, input logic [1:0] c);
        logic [42:0] e;
        logic [39:0] r;
        logic [5:0] s;
        logic [31:0] m;
        logic ok;
        e = model(op, o, a, c);
        s = 6'($urandom);
        m = $urandom;
        ok = (op != 8'ha8) || (f == 8'h93);
        bus(1, `RMRU_OFS_CTRL, {30'h0, c});
        bus(1, `RMRU_OFS_OPERANDS, o);
        bus(1, `RMRU_OFS_ACC_LO, a[31:0]);
        bus(1, `RMRU_OFS_ACC_HI, {24'h0, a[39:32]});
        bus(1, `RMRU_OFS_INDEX, {10'h0, s ^ 6'h1, 10'h0, s});
        bus(1, `RMRU_OFS_DPRAM_BASE + {2'h0, s, 2'h0}, m);
        bus(1, `RMRU_OFS_INSTR, {f, 8'h00, op, 8'h00});
        r = ok ? e[39:0] : a;
        so |= ok & e[42];
        ss |= ok & e[41];
        bus(0, `RMRU_OFS_ACC_LO, 0);
        cmp("acc_lo", {8'h0, r[31:0]}, {8'h0, rdata});
        bus(0, `RMRU_OFS_ACC_HI, 0);
        cmp("acc_hi", {32'h0, r[39:32]}, {32'h0, rdata[7:0]});
        if (ok)
            cmp("flags", {33'h0, e[42], ss, !((&r[39:31]) | ~|r[39:31]), so, e[40], ~|r,
                r[39]}, {33'h0, flags});
        if (ok && op == 8'ha8)
        begin
            bus(0, `RMRU_OFS_DPRAM_BASE + {2'h0, s ^ 6'h1, 2'h0}, 0);
            cmp("moved", {8'h0, m}, {8'h0, rdata});
        end
        if (!ok)
        begin
            bus(0, `RMRU_OFS_IRQ_STATUS, 0);
            cmp("illegal", 40'h1, {39'h0, rdata[3]});
        end
    endtask
    initial
    begin
        {reset_n, req, wr, addr, wdata, so, ss} = '0;
        {errors, num_checks, cycles} = '0;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        void'($urandom(7));
        @(negedge clock);
        cmp("reset flags", 40'h0, {33'h0, flags});
        // corners: shifted full-scale product, overflow into saturation
        run(8'ha3, 8'hf1, 32'h8000_8000, 40'h0, 2'h1);
        run(8'h83, 8'hf0, 32'h0, 40'h80_0000_0000, 2'h2);
        bus(1, `RMRU_OFS_IRQ_ENABLE, 32'h8);
        run(8'ha3, 8'ha8, 32'h1234_5678, 40'h5, 2'h0);
        @(negedge clock);
        cmp("irq set", 40'h1, {39'h0, irq});
        bus(1, `RMRU_OFS_IRQ_CLEAR, 32'h8);
        @(negedge clock);
        cmp("irq clear", 40'h0, {39'h0, irq});
        bus(0, 10'h100, 32'h0);
        cmp("unmapped", 40'h0, {8'h0, rdata});
        // form and opcode byte drawn at random from all three forms and seven opcodes, random operands and control
        repeat (80)
            run(forms[$urandom % 3], ops[$urandom % 7], $urandom,
                {8'($urandom), 32'($urandom)}, 2'($urandom));
        test_done();
    end
endmodule // reverse_mac_round_unit_tb_top
